// ===== hdl/divp_defs.svh
// Constants of the interrupt vector and priority block.
// Included by divp_ctrl, its checker and the bench; definitions only.
`ifndef DIVP_DEFS_SVH
`define DIVP_DEFS_SVH

`define DIVP_NUM_SRC 14
`define DIVP_DATA_W 16
`define DIVP_ADDR_W 2
`define DIVP_OFS_W 7
`define DIVP_RANK_W 5
`define DIVP_IDX_W 4
`define DIVP_TRAP_W 5

`define DIVP_ADDR_FLAGS 2'h0
`define DIVP_ADDR_MASK 2'h1
`define DIVP_ADDR_VECTOR 2'h2

`define DIVP_FLAG_USED 16'h3FFF
`define DIVP_FLAG_RESET 16'h0000
`define DIVP_MASK_RESET 16'h0000

`define DIVP_OFS_RESET 7'h00
`define DIVP_OFS_NMI 7'h04
`define DIVP_OFS_MASKABLE 7'h40
`define DIVP_OFS_TRAP_HI_BIAS 5'h0F
`define DIVP_RANK_NONE 5'h00
`define DIVP_RANK_RESET 5'h01
`define DIVP_RANK_NMI 5'h02
`define DIVP_RANK_MASKABLE 5'h03

`define DIVP_TRAP_LOW_LAST 5'h0D
`define DIVP_TRAP_NMI 5'h10
`define DIVP_TRAP_HI_FIRST 5'h11
`define DIVP_TRAP_HI_LAST 5'h1E

`define DIVP_PIN_NUM 6
`define DIVP_PIN_IDLE 6'h3F
`define DIVP_PIN_RESET 0
`define DIVP_PIN_NMI 1
`define DIVP_PIN_EXT0 2
`define DIVP_PIN_EXT1 3
`define DIVP_PIN_EXT2 4
`define DIVP_PIN_EXT3 5

`endif

// ===== hdl/divp_pkg.sv
// Types shared by the interrupt vector and priority block.
// No state; used by the top module only.
package divp_pkg;
   typedef enum logic [2:0] {
      DIVP_SRC_NONE,
      DIVP_SRC_RESET,
      DIVP_SRC_NMI,
      DIVP_SRC_TRAP,
      DIVP_SRC_MASKABLE
   } divp_src_e;

   typedef enum logic {
      DIVP_ST_IDLE,
      DIVP_ST_OFFER
   } divp_state_e;
endpackage

// ===== hdl/divp_sync3.sv
// Three-stage synchroniser for asynchronous pins.
// Output moves only when stages two and three agree.
`timescale 1ns/1ns
module divp_sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] agree;

   assign agree = ~(s2_reg ^ s3_reg);
   assign sync_out = out_reg;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= IDLE_VAL;
         s2_reg <= IDLE_VAL;
         s3_reg <= IDLE_VAL;
         out_reg <= IDLE_VAL;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= (s3_reg & agree) | (out_reg & ~agree);
      end
   end
endmodule // divp_sync3

// ===== hdl/divp_prio_enc.sv
// Fixed-priority finder: lowest set request bit wins.
// Purely combinational; caller registers the result.
`timescale 1ns/1ns
module divp_prio_enc #(
   parameter int WIDTH = 14,
   parameter int IDX_W = 4
) (
   input wire logic [WIDTH-1:0] req,
   output logic found,
   output logic [IDX_W-1:0] index
);
   always_comb begin
      found = 1'b0;
      index = '0;
      for (int i = WIDTH - 1; i >= 0; i--) begin
         if (req[i]) begin
            found = 1'b1;
            index = IDX_W'(i);
         end
      end
   end
endmodule // divp_prio_enc

// ===== hdl/divp_ctrl.sv
// Interrupt vectoring and prioritisation for the DSP core.
// Assumes pins are asynchronous and active low, peripheral
// requests are one-cycle pulses on core_clk, and the core
// sequencer acknowledges each offered vector with vec_ack.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`include "divp_defs.svh"
module divp_ctrl (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic device_reset_pin_n,
   input wire logic nonmaskable_pin_n,
   input wire logic external_request_zero_n,
   input wire logic external_request_one_n,
   input wire logic external_request_two_n,
   input wire logic external_request_three_n,
   input wire logic timer_request,
   input wire logic serial0_receive_request,
   input wire logic serial0_transmit_request,
   input wire logic serial1_receive_request,
   input wire logic serial1_transmit_request,
   input wire logic serial2_receive_request,
   input wire logic serial2_transmit_request,
   input wire logic host_port_request,
   input wire logic dma_channel_four_request,
   input wire logic dma_channel_five_request,
   input wire logic software_reset_trap,
   input wire logic soft_trap_req,
   input wire logic [`DIVP_TRAP_W-1:0] soft_trap_index,
   input wire logic vec_ack,
   input wire logic [`DIVP_ADDR_W-1:0] reg_addr,
   input wire logic [`DIVP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`DIVP_DATA_W-1:0] reg_rdata,
   output logic vec_valid,
   output logic [`DIVP_OFS_W-1:0] vec_offset,
   output logic [`DIVP_RANK_W-1:0] vec_rank,
   output logic irq
);
   // Pin synchronisation and edge detection
   logic [`DIVP_PIN_NUM-1:0] pin_raw;
   logic [`DIVP_PIN_NUM-1:0] pin_sync;
   logic [`DIVP_PIN_NUM-1:0] pin_prev_reg;
   logic [`DIVP_PIN_NUM-1:0] pin_fall;

   assign pin_raw[`DIVP_PIN_RESET] = device_reset_pin_n;
   assign pin_raw[`DIVP_PIN_NMI] = nonmaskable_pin_n;
   assign pin_raw[`DIVP_PIN_EXT0] = external_request_zero_n;
   assign pin_raw[`DIVP_PIN_EXT1] = external_request_one_n;
   assign pin_raw[`DIVP_PIN_EXT2] = external_request_two_n;
   assign pin_raw[`DIVP_PIN_EXT3] = external_request_three_n;

   divp_sync3 #(
      .WIDTH(`DIVP_PIN_NUM),
      .IDLE_VAL(`DIVP_PIN_IDLE)
   ) u_pin_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(pin_raw),
      .sync_out(pin_sync)
   );

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_prev_reg <= `DIVP_PIN_IDLE;
      end else begin
         pin_prev_reg <= pin_sync;
      end
   end

   // Requests are taken on the falling edge of each pin except reset, which acts while low
   assign pin_fall = pin_prev_reg & ~pin_sync;

   // Reset sources
   logic rst_hold;
   logic rst_event;

   assign rst_hold = ~pin_sync[`DIVP_PIN_RESET];
   assign rst_event = rst_hold | software_reset_trap;

   // Event vector, bit n is the source of trap index n
   logic [`DIVP_DATA_W-1:0] src_event;

   assign src_event = {
      2'b00,
      dma_channel_five_request,
      dma_channel_four_request,
      serial1_transmit_request,
      serial1_receive_request,
      host_port_request,
      pin_fall[`DIVP_PIN_EXT3],
      serial2_transmit_request,
      serial2_receive_request,
      serial0_transmit_request,
      serial0_receive_request,
      timer_request,
      pin_fall[`DIVP_PIN_EXT2],
      pin_fall[`DIVP_PIN_EXT1],
      pin_fall[`DIVP_PIN_EXT0]
   };

   // Register port decode
   logic wr_flags;
   logic wr_mask;
   logic rd_flags;
   logic rd_mask;
   logic rd_vector;

   assign wr_flags = reg_wr && (reg_addr == `DIVP_ADDR_FLAGS);
   assign wr_mask = reg_wr && (reg_addr == `DIVP_ADDR_MASK);
   assign rd_flags = reg_rd && (reg_addr == `DIVP_ADDR_FLAGS);
   assign rd_mask = reg_rd && (reg_addr == `DIVP_ADDR_MASK);
   assign rd_vector = reg_rd && (reg_addr == `DIVP_ADDR_VECTOR);

   // Flag and mask registers
   logic [`DIVP_DATA_W-1:0] flags_reg;
   logic [`DIVP_DATA_W-1:0] flags_next;
   logic [`DIVP_DATA_W-1:0] mask_reg;
   logic [`DIVP_DATA_W-1:0] mask_next;
   logic [`DIVP_DATA_W-1:0] flags_clr;
   logic [`DIVP_DATA_W-1:0] service_clr;

   // Offer state
   divp_pkg::divp_state_e state_reg;
   divp_pkg::divp_state_e state_next;
   divp_pkg::divp_src_e src_reg;
   logic [`DIVP_IDX_W-1:0] idx_reg;
   logic ack_taken;

   assign ack_taken = (state_reg == divp_pkg::DIVP_ST_OFFER) && vec_ack;

   // Serviced maskable source loses its flag on acknowledge
   assign service_clr = (ack_taken && src_reg == divp_pkg::DIVP_SRC_MASKABLE) ?
      (`DIVP_DATA_W'(1) << idx_reg) : '0;
   assign flags_clr = (wr_flags ? reg_wdata : '0) | service_clr;

   // A new event wins over a clear in the same cycle
   assign flags_next = rst_event ? `DIVP_FLAG_RESET :
      ((flags_reg & ~flags_clr) | src_event) & `DIVP_FLAG_USED;
   assign mask_next = rst_event ? `DIVP_MASK_RESET :
      wr_mask ? (reg_wdata & `DIVP_FLAG_USED) : mask_reg;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flags_reg <= `DIVP_FLAG_RESET;
         mask_reg <= `DIVP_MASK_RESET;
      end else begin
         flags_reg <= flags_next;
         mask_reg <= mask_next;
      end
   end

   // Maskable arbitration: lower bit means higher rank
   logic [`DIVP_NUM_SRC-1:0] armed;
   logic mask_found;
   logic [`DIVP_IDX_W-1:0] mask_idx;

   assign armed = flags_reg[`DIVP_NUM_SRC-1:0] & mask_reg[`DIVP_NUM_SRC-1:0];

   divp_prio_enc #(
      .WIDTH(`DIVP_NUM_SRC),
      .IDX_W(`DIVP_IDX_W)
   ) u_prio (
      .req(armed),
      .found(mask_found),
      .index(mask_idx)
   );

   // Software traps
   logic trap_low;
   logic trap_nmi;
   logic trap_high;
   logic trap_take;
   logic trap_pend_reg;
   logic [`DIVP_OFS_W-1:0] trap_ofs_reg;
   logic [`DIVP_OFS_W-1:0] trap_ofs_calc;
   logic [`DIVP_TRAP_W-1:0] trap_hi_slot;

   assign trap_low = soft_trap_index <= `DIVP_TRAP_LOW_LAST;
   assign trap_nmi = soft_trap_index == `DIVP_TRAP_NMI;
   assign trap_high = (soft_trap_index >= `DIVP_TRAP_HI_FIRST) &&
      (soft_trap_index <= `DIVP_TRAP_HI_LAST);
   // Reserved indices and a second trap while one waits are ignored
   assign trap_take = soft_trap_req && !trap_pend_reg && (trap_low || trap_high);
   assign trap_hi_slot = soft_trap_index - `DIVP_OFS_TRAP_HI_BIAS;
   assign trap_ofs_calc = trap_low ?
      (`DIVP_OFS_MASKABLE | {1'b0, soft_trap_index[`DIVP_IDX_W-1:0], 2'b00}) :
      {1'b0, trap_hi_slot[`DIVP_IDX_W-1:0], 2'b00};

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         trap_ofs_reg <= `DIVP_OFS_RESET;
      end else if (trap_take) begin
         trap_ofs_reg <= trap_ofs_calc;
      end
   end

   // Pending reset, non-maskable and trap requests
   logic rst_pend_reg;
   logic nmi_pend_reg;
   logic nmi_event;
   logic served_rst;
   logic served_nmi;
   logic served_trap;

   assign nmi_event = pin_fall[`DIVP_PIN_NMI] || (soft_trap_req && trap_nmi);
   assign served_rst = ack_taken && src_reg == divp_pkg::DIVP_SRC_RESET;
   assign served_nmi = ack_taken && src_reg == divp_pkg::DIVP_SRC_NMI;
   assign served_trap = ack_taken && src_reg == divp_pkg::DIVP_SRC_TRAP;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_pend_reg <= 1'b1;
         nmi_pend_reg <= 1'b0;
         trap_pend_reg <= 1'b0;
      end else begin
         rst_pend_reg <= rst_event | (rst_pend_reg & ~served_rst);
         nmi_pend_reg <= !rst_event && (nmi_event || (nmi_pend_reg && !served_nmi));
         trap_pend_reg <= !rst_event && (trap_take || (trap_pend_reg && !served_trap));
      end
   end

   // Selection: reset, then non-maskable, then trap, then maskable
   logic pick_rst;
   logic pick_nmi;
   logic pick_trap;
   logic pick_mask;
   logic pick_any;
   logic [`DIVP_OFS_W-1:0] pick_ofs;
   logic [`DIVP_OFS_W-1:0] mask_ofs;
   logic [`DIVP_RANK_W-1:0] pick_rank;
   logic [`DIVP_RANK_W-1:0] mask_rank;
   divp_pkg::divp_src_e pick_src;

   assign pick_rst = rst_pend_reg;
   assign pick_nmi = !pick_rst && nmi_pend_reg;
   assign pick_trap = !pick_rst && !nmi_pend_reg && trap_pend_reg;
   assign pick_mask = !pick_rst && !nmi_pend_reg && !trap_pend_reg && mask_found;
   assign pick_any = pick_rst || nmi_pend_reg || trap_pend_reg || mask_found;

   assign mask_ofs = `DIVP_OFS_MASKABLE | {1'b0, mask_idx, 2'b00};
   assign mask_rank = `DIVP_RANK_MASKABLE + {1'b0, mask_idx};

   assign pick_ofs = pick_rst ? `DIVP_OFS_RESET :
      pick_nmi ? `DIVP_OFS_NMI :
      pick_trap ? trap_ofs_reg : mask_ofs;
   assign pick_rank = pick_rst ? `DIVP_RANK_RESET :
      pick_nmi ? `DIVP_RANK_NMI :
      pick_trap ? `DIVP_RANK_NONE : mask_rank;
   assign pick_src = pick_rst ? divp_pkg::DIVP_SRC_RESET :
      pick_nmi ? divp_pkg::DIVP_SRC_NMI :
      pick_trap ? divp_pkg::DIVP_SRC_TRAP :
      pick_mask ? divp_pkg::DIVP_SRC_MASKABLE : divp_pkg::DIVP_SRC_NONE;

   // Offer machine; a new reset withdraws any other offer
   logic preempt;

   assign preempt = rst_event && src_reg != divp_pkg::DIVP_SRC_RESET;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         divp_pkg::DIVP_ST_IDLE: begin
            if (pick_any) begin
               state_next = divp_pkg::DIVP_ST_OFFER;
            end
         end
         divp_pkg::DIVP_ST_OFFER: begin
            if (vec_ack || preempt) begin
               state_next = divp_pkg::DIVP_ST_IDLE;
            end
         end
      endcase
   end

   logic load_offer;
   logic vec_valid_reg;
   logic [`DIVP_OFS_W-1:0] vec_offset_reg;
   logic [`DIVP_RANK_W-1:0] vec_rank_reg;

   // Frozen while offered so the core sees a stable vector
   assign load_offer = (state_reg == divp_pkg::DIVP_ST_IDLE) && pick_any;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= divp_pkg::DIVP_ST_IDLE;
         vec_valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         vec_valid_reg <= state_next == divp_pkg::DIVP_ST_OFFER;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         src_reg <= divp_pkg::DIVP_SRC_NONE;
         idx_reg <= '0;
         vec_offset_reg <= `DIVP_OFS_RESET;
         vec_rank_reg <= `DIVP_RANK_NONE;
      end else if (load_offer) begin
         src_reg <= pick_src;
         idx_reg <= mask_idx;
         vec_offset_reg <= pick_ofs;
         vec_rank_reg <= pick_rank;
      end
   end

   // Read path and interrupt line
   logic [`DIVP_DATA_W-1:0] vector_word;
   logic [`DIVP_DATA_W-1:0] rdata_sel;
   logic [`DIVP_DATA_W-1:0] rdata_reg;
   logic irq_reg;

   assign vector_word = {vec_valid_reg, 3'b000, vec_rank_reg, vec_offset_reg};
   assign rdata_sel = rd_flags ? flags_reg :
      rd_mask ? mask_reg :
      rd_vector ? vector_word : '0;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_sel;
         irq_reg <= |(flags_next & mask_next);
      end
   end

   assign reg_rdata = rdata_reg;
   assign vec_valid = vec_valid_reg;
   assign vec_offset = vec_offset_reg;
   assign vec_rank = vec_rank_reg;
   assign irq = irq_reg;
endmodule // divp_ctrl

// ===== tb/divp_ctrl_checker.sv
// Port-level assertions for the interrupt vector block.
// Bound to divp_ctrl from the bench top; sees its ports only.
`timescale 1ns/1ns
`include "divp_defs.svh"
module divp_ctrl_checker (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic vec_ack,
   input wire logic [`DIVP_ADDR_W-1:0] reg_addr,
   input wire logic [`DIVP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`DIVP_DATA_W-1:0] reg_rdata,
   input wire logic vec_valid,
   input wire logic [`DIVP_OFS_W-1:0] vec_offset,
   input wire logic [`DIVP_RANK_W-1:0] vec_rank,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_first_offer: assert property ($rose(nrst) |=> vec_valid && vec_rank == 5'h01 && vec_offset == 7'h00)
      else $error("first offer is not the reset vector");
   a_reset_slot: assert property (vec_valid && vec_rank == 5'h01 |-> vec_offset == 7'h00)
      else $error("reset rank with wrong offset");
   a_nmi_slot: assert property (vec_valid && vec_rank == 5'h02 |-> vec_offset == 7'h04)
      else $error("nonmaskable rank with wrong offset");
   a_rank_map: assert property (vec_valid && vec_rank >= 5'h03 |-> vec_rank <= 5'h10 &&
      vec_offset == {vec_rank - 5'h03, 2'b00} + 7'h40)
      else $error("maskable rank and offset disagree");
   a_trap_slot: assert property (vec_valid && vec_rank == 5'h00 |->
      vec_offset[1:0] == 2'b00 && vec_offset >= 7'h08 && vec_offset < 7'h78)
      else $error("trap offset outside its slots");
   a_offer_hold: assert property (vec_valid && $past(vec_valid) |-> $stable(vec_offset) && $stable(vec_rank))
      else $error("offered vector changed while offered");
   a_ack_drop: assert property (vec_valid && vec_ack |=> !vec_valid)
      else $error("offer stayed after acknowledge");
   a_irq_masked: assert property (reg_wr && reg_addr == `DIVP_ADDR_MASK && reg_wdata[13:0] == 14'h0000 |=> !irq)
      else $error("irq high with all sources masked");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) != `DIVP_ADDR_VECTOR |->
      reg_rdata[15:14] == 2'h0)
      else $error("reserved bits read nonzero");
   a_unmapped_read: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 16'h0000)
      else $error("unmapped read nonzero");

   c_reset_taken: cover property (vec_valid && vec_ack && vec_rank == 5'h01);
   c_lowest_taken: cover property (vec_valid && vec_ack && vec_rank == 5'h10);
   c_trap_taken: cover property (vec_valid && vec_ack && vec_rank == 5'h00);
   c_irq_rise: cover property ($rose(irq));
endmodule // divp_ctrl_checker

// ===== tb/divp_core_model.sv
// Core sequencer stand-in: takes each offered vector after a set lag.
// Records the last vector taken and counts them; never acks early.
`timescale 1ns/1ns
module divp_core_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic vec_valid,
   input wire logic [6:0] vec_offset,
   input wire logic [4:0] vec_rank,
   input wire logic acc_en,
   input wire logic [3:0] lag,
   output logic vec_ack,
   output logic [6:0] seen_ofs,
   output logic [4:0] seen_rank,
   output logic [15:0] taken
);
   logic [3:0] wait_reg;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         vec_ack <= 1'b0;
         wait_reg <= 4'h0;
         taken <= 16'h0000;
         seen_ofs <= 7'h00;
         seen_rank <= 5'h00;
      end else if (vec_valid && vec_ack) begin
         vec_ack <= 1'b0;
         wait_reg <= 4'h0;
         taken <= taken + 16'h0001;
         seen_ofs <= vec_offset;
         seen_rank <= vec_rank;
      end else if (!vec_valid) begin
         // Withdrawn offer: drop a pending ack so it cannot hit the next one
         vec_ack <= 1'b0;
         wait_reg <= 4'h0;
      end else if (acc_en && !vec_ack) begin
         if (wait_reg >= lag) begin
            vec_ack <= 1'b1;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule // divp_core_model

// ===== tb/test_dsp_interrupt_vector_priority.sv
// Self-checking bench for divp_ctrl with a core sequencer model.
// Assumes the checker is compiled alongside; bound at the foot.
`timescale 1ns/1ns
`include "divp_defs.svh"
module test_dsp_interrupt_vector_priority;
   typedef struct {int src; logic [6:0] ofs; logic [4:0] rank;} divp_row_s;
   divp_row_s rows [14] = '{'{0, 7'h40, 5'h03}, '{1, 7'h44, 5'h04}, '{2, 7'h48, 5'h05}, '{3, 7'h4C, 5'h06},
      '{4, 7'h50, 5'h07}, '{5, 7'h54, 5'h08}, '{6, 7'h58, 5'h09}, '{7, 7'h5C, 5'h0A}, '{8, 7'h60, 5'h0B},
      '{9, 7'h64, 5'h0C}, '{10, 7'h68, 5'h0D}, '{11, 7'h6C, 5'h0E}, '{12, 7'h70, 5'h0F}, '{13, 7'h74, 5'h10}};
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] pin_n = `DIVP_PIN_IDLE;
   logic [13:0] pls = 14'h0000;
   logic software_reset_trap = 1'b0;
   logic soft_trap_req = 1'b0;
   logic [4:0] soft_trap_index = 5'h00;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic acc_en = 1'b1;
   logic [3:0] lag = 4'h0;
   logic [15:0] reg_rdata, rdv, taken;
   logic vec_valid, vec_ack, irq;
   logic [6:0] vec_offset, seen_ofs;
   logic [4:0] vec_rank, seen_rank;
   int err_count = 0;
   int n_tests = 0;

   always #5 core_clk = ~core_clk;

   divp_ctrl u_dut (.core_clk, .nrst, .device_reset_pin_n(pin_n[`DIVP_PIN_RESET]),
      .nonmaskable_pin_n(pin_n[`DIVP_PIN_NMI]), .external_request_zero_n(pin_n[`DIVP_PIN_EXT0]),
      .external_request_one_n(pin_n[`DIVP_PIN_EXT1]), .external_request_two_n(pin_n[`DIVP_PIN_EXT2]),
      .external_request_three_n(pin_n[`DIVP_PIN_EXT3]), .timer_request(pls[3]),
      .serial0_receive_request(pls[4]), .serial0_transmit_request(pls[5]), .serial2_receive_request(pls[6]),
      .serial2_transmit_request(pls[7]), .host_port_request(pls[9]), .serial1_receive_request(pls[10]),
      .serial1_transmit_request(pls[11]), .dma_channel_four_request(pls[12]),
      .dma_channel_five_request(pls[13]), .software_reset_trap, .soft_trap_req, .soft_trap_index, .vec_ack,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vec_valid, .vec_offset, .vec_rank, .irq);

   divp_core_model u_core (.core_clk, .nrst, .vec_valid, .vec_offset, .vec_rank, .acc_en, .lag, .vec_ack,
      .seen_ofs, .seen_rank, .taken);

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [1:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata;
      @(posedge core_clk);
   endtask

   task automatic rchk(input logic [1:0] a, input string nm, input logic [15:0] e);
      rd(a);
      chk(nm, rdv, e);
   endtask

   // Pins need several cycles low to clear the synchroniser
   task automatic fire(input int n);
      if (n < 3 || n == 8) begin
         pin_n[n == 8 ? `DIVP_PIN_EXT3 : `DIVP_PIN_EXT0 + n] <= 1'b0;
         repeat (8) @(posedge core_clk);
         pin_n <= `DIVP_PIN_IDLE;
      end else begin
         pls[n] <= 1'b1;
         @(posedge core_clk);
         pls <= 14'h0000;
      end
   endtask

   task automatic wvalid();
      int k;
      k = 0;
      while (vec_valid !== 1'b1 && k < 50) begin
         @(posedge core_clk);
         k++;
      end
      chk("offer", vec_valid, 1'b1);
      if (vec_valid !== 1'b1) conclude();
   endtask

   task automatic wack(input logic [6:0] o, input logic [4:0] r);
      logic [15:0] c;
      int k;
      c = taken;
      k = 0;
      while (taken === c && k < 300) begin
         @(posedge core_clk);
         k++;
      end
      chk("ack wait", taken !== c, 1'b1);
      if (taken === c) conclude();
      chk("offset", seen_ofs, o);
      chk("rank", seen_rank, r);
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      wack(7'h00, 5'h01);
      rchk(2'h0, "flags", 16'h0000);
      rchk(2'h1, "mask", 16'h0000);
      rchk(2'h3, "unmapped", 16'h0000);
      wr(2'h1, 16'hFFFF);
      rchk(2'h1, "mask", 16'h3FFF);
      foreach (rows[i]) begin
         acc_en <= 1'b0;
         lag <= rows[i].src[0] ? 4'h4 : 4'h0;
         fire(rows[i].src);
         wvalid();
         chk("irq", irq, 1'b1);
         rchk(2'h0, "flags", 16'h0001 << rows[i].src);
         rchk(2'h2, "vector", {1'b1, 3'h0, rows[i].rank, rows[i].ofs});
         acc_en <= 1'b1;
         wack(rows[i].ofs, rows[i].rank);
         @(posedge core_clk);
         rchk(2'h0, "flags", 16'h0000);
         chk("irq", irq, 1'b0);
      end
      wr(2'h1, 16'hC000);
      rchk(2'h1, "mask", 16'h0000);
      wr(2'h1, 16'h3FF7);
      fire(3);
      repeat (6) @(posedge core_clk);
      chk("irq", irq, 1'b0);
      chk("valid", vec_valid, 1'b0);
      rchk(2'h0, "flags", 16'h0008);
      wr(2'h0, 16'hC000);
      rchk(2'h0, "flags", 16'h0008);
      wr(2'h0, 16'h0008);
      rchk(2'h0, "flags", 16'h0000);
      // Every source but reset pending at once, then drained in priority order
      wr(2'h1, 16'hFFFF);
      acc_en <= 1'b0;
      lag <= 4'h0;
      pin_n <= 6'h01;
      repeat (8) @(posedge core_clk);
      pin_n <= `DIVP_PIN_IDLE;
      pls <= 14'h3EF8;
      soft_trap_req <= 1'b1;
      soft_trap_index <= 5'h11;
      @(posedge core_clk);
      pls <= 14'h0000;
      soft_trap_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      acc_en <= 1'b1;
      wack(7'h04, 5'h02);
      wack(7'h08, 5'h00);
      foreach (rows[i]) wack(rows[i].ofs, rows[i].rank);
      for (int i = 0; i < 31; i++) begin
         soft_trap_req <= 1'b1;
         soft_trap_index <= 5'(i);
         @(posedge core_clk);
         soft_trap_req <= 1'b0;
         if (i == 14 || i == 15) begin
            // Reserved index; a wrong offer would already stand here
            repeat (2) @(posedge core_clk);
            chk("reserved trap", vec_valid, 1'b0);
         end else if (i == 16) begin
            wack(7'h04, 5'h02);
         end else if (i > 16) begin
            wack(7'(4 * (i - 15)), 5'h00);
         end else begin
            wack(7'(7'h40 + 4 * i), 5'h00);
         end
      end
      // Software reset withdraws a standing timer offer
      wr(2'h1, 16'h0008);
      acc_en <= 1'b0;
      fire(3);
      wvalid();
      software_reset_trap <= 1'b1;
      @(posedge core_clk);
      software_reset_trap <= 1'b0;
      acc_en <= 1'b1;
      wack(7'h00, 5'h01);
      rchk(2'h0, "flags", 16'h0000);
      rchk(2'h1, "mask", 16'h0000);
      wr(2'h1, 16'h0003);
      pin_n <= 6'h3E;
      wack(7'h00, 5'h01);
      pin_n <= `DIVP_PIN_IDLE;
      repeat (20) @(posedge core_clk);
      rchk(2'h1, "mask", 16'h0000);
      conclude();
   end
endmodule // test_dsp_interrupt_vector_priority

bind divp_ctrl divp_ctrl_checker u_chk (.core_clk, .nrst, .vec_ack, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .vec_valid, .vec_offset, .vec_rank, .irq);
